// ===== hdl/jdr_consts.vh
// constants for the test-port data register set
`ifndef JDR_CONSTS_VH
`define JDR_CONSTS_VH
`define JDR_IR_W 6
`define JDR_OP_EXTEST 6'h00
`define JDR_OP_SAMPLE 6'h01
`define JDR_OP_FIRST_CHAIN 6'h02
`define JDR_OP_SECOND_CHAIN 6'h03
`define JDR_OP_CFG_RD 6'h04
`define JDR_OP_CFG_WR 6'h05
`define JDR_OP_INTEST 6'h07
`define JDR_OP_UCODE 6'h08
`define JDR_OP_IDENT 6'h09
`define JDR_OP_HIGHZ 6'h0A
`define JDR_OP_BYPASS 6'h3F
`define JDR_IR_FIXED 2'h1
`define JDR_ID_W 32
`define JDR_CFG_W 64
`define JDR_FIFO_DEPTH 8
`define JDR_NUM_BLOCK 4
`define JDR_NUM_INONLY 2
`define JDR_CELLS_PER_BLOCK 3
`define JDR_CELL_OE 0
`define JDR_CELL_OUT 1
`define JDR_CELL_IN 2
// identity fields, values arbitrary
`define JDR_ID_REV 4'h1
`define JDR_ID_FAMILY 7'h55
`define JDR_ID_ROWS 9'h0A5
`define JDR_ID_COMPANY 11'h2AA
`define JDR_UCODE_UNCONF 32'hFFFFFFFF
`endif

// ===== hdl/jdr_regs.v
// test-port data registers with config write fifo
`timescale 1ns/1ps
`include "jdr_consts.vh"

module jdr_fifo #(
	parameter W = 64,
	parameter D = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	assign in_ready = (count != D);
	assign out_valid = (count != 0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule

// Notes on behaviour
// - instruction register is six bits, capture loads status.
// - three boundary cells per io_block, bonded or not.
// - per block input, output, then enable cell nearest serial out.
// - input-only pin adds a single input cell.
// - chain order and length fixed, independent of loaded design.
// - capture-DR loads parallel data, shift-DR moves one bit per TCK.
// - update latches hold outputs, loaded in update-DR while TCK low.
// - bypass is one flop loading zero at capture-DR.
// - 64-bit register reaches config bus for load and readback.
// - id layout revision, family, rows, company, bit 0.
// - captured identification bit 0 is always one.
// - user code register returns design value after configuration.
// - user chains reach design registers only after configuration.
// - select output per user chain while its instruction is current.
// - chain return data routed to serial out while shifting.
// - separate data register clock for each user chain.
// - shared serial input copy plus reset, shift, update indicators.
// - test pins dedicated; standard instructions need no user chain.
// - opcodes decoded as listed, bypass all ones.
// - serial out changes on TCK fall, driven only while shifting.
// - serial input sampled on TCK rise.
module jdr_regs (
	input wire CLOCK,
	input wire RESET_N,
	input wire TCK,
	input wire TMS,
	input wire TDI,
	output reg TDO,
	output reg TDO_OE,
	input wire [`JDR_NUM_BLOCK-1:0] IO_PIN_IN,
	input wire [`JDR_NUM_INONLY-1:0] INONLY_PIN_IN,
	output wire [`JDR_NUM_BLOCK-1:0] IO_PIN_OUT,
	output wire [`JDR_NUM_BLOCK-1:0] IO_PIN_OE,
	input wire [`JDR_NUM_BLOCK-1:0] CORE_OUT,
	input wire [`JDR_NUM_BLOCK-1:0] CORE_OE,
	output wire [`JDR_NUM_BLOCK-1:0] CORE_IN,
	output wire [`JDR_NUM_INONLY-1:0] CORE_INONLY_IN,
	input wire CONFIG_DONE,
	input wire [`JDR_ID_W-1:0] USER_CODE,
	input wire [`JDR_CFG_W-1:0] CFG_READ_DATA,
	output wire CFG_WR_VALID,
	input wire CFG_WR_READY,
	output wire [`JDR_CFG_W-1:0] CFG_WR_DATA,
	output reg FIRST_CHAIN_SELECT,
	output reg SECOND_CHAIN_SELECT,
	input wire FIRST_CHAIN_RETURN_DATA,
	input wire SECOND_CHAIN_RETURN_DATA,
	output reg FIRST_CHAIN_CLOCK,
	output reg SECOND_CHAIN_CLOCK,
	output reg CHAIN_TDI,
	output reg TAP_RESET,
	output reg TAP_SHIFT,
	output reg TAP_UPDATE
);
	localparam NIOB = `JDR_NUM_BLOCK;
	localparam NIN = `JDR_NUM_INONLY;
	localparam NB = NIOB * `JDR_CELLS_PER_BLOCK + NIN;
	localparam S_TLR = 4'h0;
	localparam S_RTI = 4'h1;
	localparam S_SELDR = 4'h2;
	localparam S_CAPDR = 4'h3;
	localparam S_SHDR = 4'h4;
	localparam S_EX1DR = 4'h5;
	localparam S_PADR = 4'h6;
	localparam S_EX2DR = 4'h7;
	localparam S_UPDR = 4'h8;
	localparam S_SELIR = 4'h9;
	localparam S_CAPIR = 4'hA;
	localparam S_SHIR = 4'hB;
	localparam S_EX1IR = 4'hC;
	localparam S_PAIR = 4'hD;
	localparam S_EX2IR = 4'hE;
	localparam S_UPIR = 4'hF;

	reg [2:0] tck_s;
	reg [1:0] tms_s;
	reg [1:0] tdi_s;
	reg [NIOB-1:0] pin_s1;
	reg [NIOB-1:0] pin_s2;
	reg [NIN-1:0] inp_s1;
	reg [NIN-1:0] inp_s2;
	wire tck_rise;
	wire tck_fall;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [`JDR_IR_W-1:0] ir;
	reg [`JDR_IR_W-1:0] ir_sh;
	reg bypass;
	reg [`JDR_ID_W-1:0] id_sh;
	reg [`JDR_ID_W-1:0] uc_sh;
	reg [`JDR_CFG_W-1:0] cfg_sh;
	reg [NB-1:0] bsr;
	reg [NB-1:0] upd;
	wire [NB-1:0] cap_vec;
	wire [`JDR_ID_W-1:0] id_value;
	wire fifo_in_ready;
	wire fifo_push;
	wire sel_bsr;
	wire sel_id;
	wire sel_uc;
	wire sel_cfg;
	wire sel_u1;
	wire sel_u2;
	wire pin_drive;
	reg next_tdo;

	assign tck_rise = tck_s[1] & ~tck_s[2];
	assign tck_fall = ~tck_s[1] & tck_s[2];

	// pins pass two flops before use
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			tck_s <= 3'h0;
			tms_s <= 2'h3;
			tdi_s <= 2'h3;
			pin_s1 <= {NIOB{1'b0}};
			pin_s2 <= {NIOB{1'b0}};
			inp_s1 <= {NIN{1'b0}};
			inp_s2 <= {NIN{1'b0}};
		end else begin
			tck_s <= {tck_s[1:0], TCK};
			tms_s <= {tms_s[0], TMS};
			tdi_s <= {tdi_s[0], TDI};
			pin_s1 <= IO_PIN_IN;
			pin_s2 <= pin_s1;
			inp_s1 <= INONLY_PIN_IN;
			inp_s2 <= inp_s1;
		end
	end

	always @* begin
		case (state)
			S_TLR: next_state = tms_s[1] ? S_TLR : S_RTI;
			S_RTI: next_state = tms_s[1] ? S_SELDR : S_RTI;
			S_SELDR: next_state = tms_s[1] ? S_SELIR : S_CAPDR;
			S_CAPDR: next_state = tms_s[1] ? S_EX1DR : S_SHDR;
			S_SHDR: next_state = tms_s[1] ? S_EX1DR : S_SHDR;
			S_EX1DR: next_state = tms_s[1] ? S_UPDR : S_PADR;
			S_PADR: next_state = tms_s[1] ? S_EX2DR : S_PADR;
			S_EX2DR: next_state = tms_s[1] ? S_UPDR : S_SHDR;
			S_UPDR: next_state = tms_s[1] ? S_SELDR : S_RTI;
			S_SELIR: next_state = tms_s[1] ? S_TLR : S_CAPIR;
			S_CAPIR: next_state = tms_s[1] ? S_EX1IR : S_SHIR;
			S_SHIR: next_state = tms_s[1] ? S_EX1IR : S_SHIR;
			S_EX1IR: next_state = tms_s[1] ? S_UPIR : S_PAIR;
			S_PAIR: next_state = tms_s[1] ? S_EX2IR : S_PAIR;
			S_EX2IR: next_state = tms_s[1] ? S_UPIR : S_SHIR;
			S_UPIR: next_state = tms_s[1] ? S_SELDR : S_RTI;
			default: next_state = S_TLR;
		endcase
	end

	// opcode decode; unlisted codes fall to bypass
	assign sel_bsr = (ir == `JDR_OP_EXTEST) | (ir == `JDR_OP_SAMPLE) |
		(ir == `JDR_OP_INTEST);
	assign sel_id = (ir == `JDR_OP_IDENT);
	assign sel_uc = (ir == `JDR_OP_UCODE);
	assign sel_cfg = (ir == `JDR_OP_CFG_RD) | (ir == `JDR_OP_CFG_WR);
	assign sel_u1 = (ir == `JDR_OP_FIRST_CHAIN) & CONFIG_DONE;
	assign sel_u2 = (ir == `JDR_OP_SECOND_CHAIN) & CONFIG_DONE;
	assign pin_drive = (ir == `JDR_OP_EXTEST);

	assign id_value = {`JDR_ID_REV, `JDR_ID_FAMILY, `JDR_ID_ROWS,
		`JDR_ID_COMPANY, 1'b1};

	// boundary cells: enable at 3k, output 3k+1, input 3k+2
	genvar k;
	generate
		for (k = 0; k < NIOB; k = k + 1) begin : g_block
			assign cap_vec[3*k+`JDR_CELL_OE] = CORE_OE[k];
			assign cap_vec[3*k+`JDR_CELL_OUT] = CORE_OUT[k];
			assign cap_vec[3*k+`JDR_CELL_IN] = pin_s2[k];
			assign IO_PIN_OUT[k] = pin_drive ?
				upd[3*k+`JDR_CELL_OUT] : CORE_OUT[k];
			assign IO_PIN_OE[k] = (ir == `JDR_OP_HIGHZ) ? 1'b0 :
				pin_drive ? upd[3*k+`JDR_CELL_OE] : CORE_OE[k];
			assign CORE_IN[k] = (ir == `JDR_OP_INTEST) ?
				upd[3*k+`JDR_CELL_IN] : pin_s2[k];
		end
		for (k = 0; k < NIN; k = k + 1) begin : g_inonly
			assign cap_vec[3*NIOB+k] = inp_s2[k];
			assign CORE_INONLY_IN[k] = (ir == `JDR_OP_INTEST) ?
				upd[3*NIOB+k] : inp_s2[k];
		end
	endgenerate

	// config load pushes into the fifo; refused when full
	assign fifo_push = tck_rise & (state == S_UPDR) &
		(ir == `JDR_OP_CFG_WR);

	jdr_fifo #(
		.W(`JDR_CFG_W),
		.D(`JDR_FIFO_DEPTH),
		.AW(3)
	) u_fifo (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(cfg_sh),
		.out_valid(CFG_WR_VALID),
		.out_ready(CFG_WR_READY),
		.out_data(CFG_WR_DATA)
	);

	// rising TCK: state advance, capture and shift
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= S_TLR;
			ir_sh <= `JDR_OP_IDENT;
			bypass <= 1'b0;
			id_sh <= {`JDR_ID_W{1'b0}};
			uc_sh <= {`JDR_ID_W{1'b0}};
			cfg_sh <= {`JDR_CFG_W{1'b0}};
			bsr <= {NB{1'b0}};
		end else if (tck_rise) begin
			state <= next_state;
			case (state)
				S_CAPIR: begin
					ir_sh <= {CONFIG_DONE, ~fifo_in_ready,
						CFG_WR_VALID, 1'b0, `JDR_IR_FIXED};
				end
				S_SHIR: begin
					ir_sh <= {tdi_s[1], ir_sh[`JDR_IR_W-1:1]};
				end
				S_CAPDR: begin
					bypass <= 1'b0;
					id_sh <= id_value;
					uc_sh <= CONFIG_DONE ? USER_CODE :
						`JDR_UCODE_UNCONF;
					cfg_sh <= CFG_READ_DATA;
					bsr <= cap_vec;
				end
				S_SHDR: begin
					bypass <= tdi_s[1];
					if (sel_id)
						id_sh <= {tdi_s[1], id_sh[`JDR_ID_W-1:1]};
					if (sel_uc)
						uc_sh <= {tdi_s[1], uc_sh[`JDR_ID_W-1:1]};
					if (sel_cfg)
						cfg_sh <= {tdi_s[1],
							cfg_sh[`JDR_CFG_W-1:1]};
					if (sel_bsr)
						bsr <= {tdi_s[1], bsr[NB-1:1]};
				end
				default: begin
				end
			endcase
		end
	end

	always @* begin
		if (state == S_SHIR)
			next_tdo = ir_sh[0];
		else if (sel_bsr)
			next_tdo = bsr[0];
		else if (sel_id)
			next_tdo = id_sh[0];
		else if (sel_uc)
			next_tdo = uc_sh[0];
		else if (sel_cfg)
			next_tdo = cfg_sh[0];
		else if (sel_u1)
			next_tdo = FIRST_CHAIN_RETURN_DATA;
		else if (sel_u2)
			next_tdo = SECOND_CHAIN_RETURN_DATA;
		else
			next_tdo = bypass;
	end

	// falling TCK: serial out, instruction and latch update
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ir <= `JDR_OP_IDENT;
			upd <= {NB{1'b0}};
			TDO <= 1'b0;
			TDO_OE <= 1'b0;
		end else begin
			if (state == S_TLR)
				ir <= `JDR_OP_IDENT;
			else if (tck_fall & (state == S_UPIR))
				ir <= ir_sh;
			if (tck_fall & (state == S_UPDR) & sel_bsr)
				upd <= bsr;
			if (tck_fall) begin
				TDO <= next_tdo;
				TDO_OE <= (state == S_SHDR) | (state == S_SHIR);
			end
		end
	end

	// internal chain interface outputs
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			FIRST_CHAIN_SELECT <= 1'b0;
			SECOND_CHAIN_SELECT <= 1'b0;
			FIRST_CHAIN_CLOCK <= 1'b0;
			SECOND_CHAIN_CLOCK <= 1'b0;
			CHAIN_TDI <= 1'b1;
			TAP_RESET <= 1'b1;
			TAP_SHIFT <= 1'b0;
			TAP_UPDATE <= 1'b0;
		end else begin
			FIRST_CHAIN_SELECT <= sel_u1;
			SECOND_CHAIN_SELECT <= sel_u2;
			// one full pulse per capture or shift edge, none on entry
			if (tck_rise) begin
				FIRST_CHAIN_CLOCK <= sel_u1 &
					((state == S_CAPDR) | (state == S_SHDR));
				SECOND_CHAIN_CLOCK <= sel_u2 &
					((state == S_CAPDR) | (state == S_SHDR));
			end else if (tck_fall) begin
				FIRST_CHAIN_CLOCK <= 1'b0;
				SECOND_CHAIN_CLOCK <= 1'b0;
			end
			CHAIN_TDI <= tdi_s[1];
			TAP_RESET <= (state == S_TLR);
			TAP_SHIFT <= (state == S_SHDR);
			TAP_UPDATE <= (state == S_UPDR);
		end
	end
endmodule

// ===== tb/jdr_checker.sv
// assertion checker for the test-port register set
`timescale 1ns/1ps
module jdr_checker (
	input wire CLOCK,
	input wire RESET_N,
	input wire TCK,
	input wire TDI,
	input wire TDO,
	input wire TDO_OE,
	input wire CONFIG_DONE,
	input wire CFG_WR_VALID,
	input wire CFG_WR_READY,
	input wire [63:0] CFG_WR_DATA,
	input wire FIRST_CHAIN_SELECT,
	input wire SECOND_CHAIN_SELECT,
	input wire FIRST_CHAIN_CLOCK,
	input wire SECOND_CHAIN_CLOCK,
	input wire CHAIN_TDI,
	input wire TAP_RESET,
	input wire TAP_SHIFT,
	input wire TAP_UPDATE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	sequence s_tdi_quiet;
		$stable(TDI)[*5];
	endsequence
	sequence s_cfg_held;
		CFG_WR_VALID && $stable(CFG_WR_DATA);
	endsequence
	property p_tdo_fall;
		!$stable(TDO) |-> !TCK;
	endproperty
	property p_oe_fall;
		!$stable(TDO_OE) |-> !TCK;
	endproperty
	property p_oe_reset;
		TAP_RESET |-> !TDO_OE;
	endproperty
	property p_shift_oe;
		$rose(TAP_SHIFT) |-> ##[1:12] TDO_OE;
	endproperty
	property p_sel_done;
		(FIRST_CHAIN_SELECT || SECOND_CHAIN_SELECT) |-> CONFIG_DONE;
	endproperty
	property p_sel_one;
		!(FIRST_CHAIN_SELECT && SECOND_CHAIN_SELECT);
	endproperty
	property p_chain_clk;
		(!FIRST_CHAIN_CLOCK || FIRST_CHAIN_SELECT) &&
			(!SECOND_CHAIN_CLOCK || SECOND_CHAIN_SELECT);
	endproperty
	property p_chain_tdi;
		s_tdi_quiet |-> CHAIN_TDI == TDI;
	endproperty
	property p_cfg_hold;
		CFG_WR_VALID && !CFG_WR_READY |=> s_cfg_held;
	endproperty
	property p_tap_excl;
		!(TAP_SHIFT && (TAP_RESET || TAP_UPDATE));
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("serial out moved with TCK high");
	a_oe_fall: assert property (p_oe_fall)
		else $error("serial enable moved with TCK high");
	a_oe_reset: assert property (p_oe_reset)
		else $error("serial out driven in reset state");
	a_shift_oe: assert property (p_shift_oe)
		else $error("serial out not driven in shift");
	a_sel_done: assert property (p_sel_done)
		else $error("chain select before configuration");
	a_sel_one: assert property (p_sel_one)
		else $error("both chain selects high");
	a_chain_clk: assert property (p_chain_clk)
		else $error("chain clock without its select");
	a_chain_tdi: assert property (p_chain_tdi)
		else $error("chain serial copy differs");
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config word dropped while stalled");
	a_tap_excl: assert property (p_tap_excl)
		else $error("state indicators overlap");
endmodule

// ===== tb/jdr_tester.sv
// tester model driving the test access port
`timescale 1ns/1ps
module jdr_tester (
	output reg tck,
	output reg tms,
	output reg tdi,
	input wire tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// inputs move while TCK low, serial out taken at the rise
	task automatic clk(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#62.5 tck = 1'b1;
		o = tdo;
		#62.5 tck = 1'b0;
	endtask
	task automatic walk(input logic [7:0] p, input int n);
		logic o;
		for (int i = 0; i < n; i++)
			clk(p[i], 1'b1, o);
	endtask
	// from idle, lsb first, ends back in idle via update
	task automatic scan(input logic is_ir, input int n,
			input logic [63:0] din, output logic [63:0] dout);
		dout = 64'h0;
		walk(is_ir ? 8'h03 : 8'h01, is_ir ? 4 : 3);
		for (int i = 0; i < n; i++)
			clk(i == n - 1, din[i], dout[i]);
		walk(8'h01, 2);
	endtask
endmodule

// ===== tb/tb.sv
// testbench for the test-port register set
`timescale 1ns/1ps
`include "jdr_consts.vh"
module tb;
	reg CLOCK = 1'b0;
	reg RESET_N = 1'b0;
	reg [3:0] IO_PIN_IN = 4'hA;
	reg [1:0] INONLY_PIN_IN = 2'h1;
	reg [3:0] CORE_OUT = 4'h5;
	reg [3:0] CORE_OE = 4'hC;
	reg CONFIG_DONE = 1'b0;
	reg [31:0] USER_CODE = 32'hC0DE1234;
	reg [63:0] CFG_READ_DATA = 64'h0123456789ABCDEF;
	reg CFG_WR_READY = 1'b0;
	reg RET1 = 1'b1;
	reg RET2 = 1'b0;
	wire TCK, TMS, TDI, TDO, TDO_OE, CFG_WR_VALID, TAP_RESET;
	wire FIRST_CHAIN_SELECT, SECOND_CHAIN_SELECT;
	wire FIRST_CHAIN_CLOCK, SECOND_CHAIN_CLOCK;
	wire [1:0] CHAIN_SELECTS = {SECOND_CHAIN_SELECT, FIRST_CHAIN_SELECT};
	wire [3:0] IO_PIN_OUT, IO_PIN_OE, CORE_IN;
	wire [1:0] CORE_INONLY_IN;
	wire [63:0] CFG_WR_DATA;
	integer miscompares = 0;
	integer comparisons = 0;
	integer pulses = 0;
	integer i, n, p0;
	logic [63:0] q;
	logic [13:0] e;
	localparam [13:0] PRE = 14'h2A5B;
	always #4 CLOCK = ~CLOCK;
	always @(posedge FIRST_CHAIN_CLOCK or posedge SECOND_CHAIN_CLOCK)
		pulses <= pulses + 1;
	jdr_tester jdr_tester_i (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO));
	jdr_regs jdr_regs_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .TCK(TCK),
		.TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE),
		.IO_PIN_IN(IO_PIN_IN), .INONLY_PIN_IN(INONLY_PIN_IN),
		.IO_PIN_OUT(IO_PIN_OUT), .IO_PIN_OE(IO_PIN_OE), .CORE_OUT(CORE_OUT),
		.CORE_OE(CORE_OE), .CORE_IN(CORE_IN),
		.CORE_INONLY_IN(CORE_INONLY_IN),
		.CONFIG_DONE(CONFIG_DONE), .USER_CODE(USER_CODE),
		.CFG_READ_DATA(CFG_READ_DATA), .CFG_WR_VALID(CFG_WR_VALID),
		.CFG_WR_READY(CFG_WR_READY), .CFG_WR_DATA(CFG_WR_DATA),
		.FIRST_CHAIN_SELECT(FIRST_CHAIN_SELECT),
		.SECOND_CHAIN_SELECT(SECOND_CHAIN_SELECT),
		.FIRST_CHAIN_RETURN_DATA(RET1), .SECOND_CHAIN_RETURN_DATA(RET2),
		.FIRST_CHAIN_CLOCK(FIRST_CHAIN_CLOCK),
		.SECOND_CHAIN_CLOCK(SECOND_CHAIN_CLOCK), .CHAIN_TDI(),
		.TAP_RESET(TAP_RESET), .TAP_SHIFT(), .TAP_UPDATE());
	task chk(input string s, input logic [63:0] x, input logic [63:0] y);
		comparisons = comparisons + 1;
		if (y !== x) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %s expected %h seen %h", s, x, y);
		end
	endtask
	task ir(input logic [5:0] op);
		jdr_tester_i.scan(1'b1, 6, {58'h0, op}, q);
	endtask
	task dr(input integer k, input logic [63:0] d);
		jdr_tester_i.scan(1'b0, k, d, q);
	endtask
	task complete_run;
		$display("mismatches %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#600000;
		miscompares = miscompares + 1;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge CLOCK);
		RESET_N <= 1'b1;
		repeat (4) @(posedge CLOCK);
		chk("tap reset", 64'h1, TAP_RESET);
		jdr_tester_i.walk(8'h1F, 6);
		dr(32, 0);
		chk("identification", {`JDR_ID_REV, `JDR_ID_FAMILY, `JDR_ID_ROWS,
			`JDR_ID_COMPANY, 1'b1}, q);
		ir(`JDR_OP_UCODE);
		chk("ir capture", 64'h01, q);
		dr(32, 0);
		chk("design code unconfigured", `JDR_UCODE_UNCONF, q);
		ir(`JDR_OP_FIRST_CHAIN);
		chk("select unconfigured", 64'h0, CHAIN_SELECTS);
		ir(`JDR_OP_BYPASS);
		dr(2, 64'h3);
		chk("bypass", 64'h2, q);
		ir(`JDR_OP_SAMPLE);
		dr(14, PRE);
		for (i = 0; i < 4; i++)
			e[3*i +: 3] = {IO_PIN_IN[i], CORE_OUT[i], CORE_OE[i]};
		e[13:12] = INONLY_PIN_IN;
		chk("boundary capture", e, q);
		ir(`JDR_OP_EXTEST);
		for (i = 0; i < 4; i++) begin
			e[i] = PRE[3*i+1];
			e[4+i] = PRE[3*i];
		end
		chk("preloaded pins", e[7:0], {IO_PIN_OE, IO_PIN_OUT});
		chk("pins to core", 64'h1A, {CORE_INONLY_IN, CORE_IN});
		ir(`JDR_OP_INTEST);
		chk("latched core inputs", {PRE[13:12], PRE[11], PRE[8],
			PRE[5], PRE[2]}, {CORE_INONLY_IN, CORE_IN});
		ir(`JDR_OP_HIGHZ);
		chk("outputs floated", 64'h0, IO_PIN_OE);
		@(posedge CLOCK) CONFIG_DONE <= 1'b1;
		ir(`JDR_OP_CFG_WR);
		for (i = 0; i < 9; i++)
			dr(64, 64'hA5000000 + i);
		chk("stalled word", 64'hA5000000, CFG_WR_DATA);
		ir(`JDR_OP_CFG_RD);
		chk("ir capture full", 64'h39, q);
		dr(64, 0);
		chk("readback", CFG_READ_DATA, q);
		@(posedge CLOCK) CFG_WR_READY <= 1'b1;
		n = 0;
		repeat (20) begin
			@(negedge CLOCK);
			if (CFG_WR_VALID === 1'b1 && CFG_WR_READY === 1'b1) begin
				chk("drained word", 64'hA5000000 + n, CFG_WR_DATA);
				n = n + 1;
			end
		end
		chk("words drained", 64'h8, n);
		ir(`JDR_OP_UCODE);
		dr(32, 0);
		chk("design code", USER_CODE, q);
		ir(`JDR_OP_FIRST_CHAIN);
		chk("select first", 64'h1, CHAIN_SELECTS);
		p0 = pulses;
		dr(4, 0);
		chk("first chain data", 64'hF, q);
		chk("first chain clocks", 64'h5, pulses - p0);
		ir(`JDR_OP_SECOND_CHAIN);
		chk("select second", 64'h2, CHAIN_SELECTS);
		p0 = pulses;
		dr(4, 64'hF);
		chk("second chain data", 64'h0, q);
		chk("second chain clocks", 64'h5, pulses - p0);
		complete_run;
	end
endmodule
bind jdr_regs jdr_checker jdr_checker_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
	.TCK(TCK), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE),
	.CONFIG_DONE(CONFIG_DONE), .CFG_WR_VALID(CFG_WR_VALID),
	.CFG_WR_READY(CFG_WR_READY), .CFG_WR_DATA(CFG_WR_DATA),
	.FIRST_CHAIN_SELECT(FIRST_CHAIN_SELECT),
	.SECOND_CHAIN_SELECT(SECOND_CHAIN_SELECT),
	.FIRST_CHAIN_CLOCK(FIRST_CHAIN_CLOCK),
	.SECOND_CHAIN_CLOCK(SECOND_CHAIN_CLOCK), .CHAIN_TDI(CHAIN_TDI),
	.TAP_RESET(TAP_RESET), .TAP_SHIFT(TAP_SHIFT), .TAP_UPDATE(TAP_UPDATE));
